// file: include/dsg_pkg.sv
// shared constants and types for the dram strobe glue controller
package dsg_pkg;
	// timing: one clock of clk_i is one half_clock_period
	localparam int CLK_PERIOD_NS = 25;
	localparam int HALF_CLOCK_PERIOD_NS = 25;
	localparam int HALF_CLOCK_CYCLES = (HALF_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MEM_CYCLE_NS = 150;
	localparam int MEM_CYCLE_STATES = MEM_CYCLE_NS / HALF_CLOCK_PERIOD_NS;
	localparam int RAS_LOW_PERIODS = 3;
	localparam int AMUX_DELAY_NS = 2;

	// bus widths
	localparam int AD_W = 32;
	localparam int WR_W = 4;
	localparam int BANKS = 2;
	localparam int DRAM_ADDR_W = 9;
	localparam int CNT_W = 8;

	// address field positions
	localparam int SPACE_BIT = 31;
	localparam int BANK_BIT = 20;
	localparam int ROW_LSB = 2;
	localparam int COL_LSB = ROW_LSB + DRAM_ADDR_W;
	localparam int REFRESH_FLAG_BIT = 1;
	localparam int REFRESH_ROW_LSB = 2;
	localparam int REFRESH_ROW_W = 10;

	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

	// processor cycle state seen from outside; idle covers T1 and E
	typedef enum logic [2:0] {
		DSG_IDLE,
		DSG_T2,
		DSG_T3,
		DSG_T4,
		DSG_WAIT,
		DSG_T5,
		DSG_T6
	} dsg_state_e;

	typedef struct packed {
		logic ram;
		logic bank;
		logic io;
		logic rom;
		logic refresh;
	} dsg_decode_s;

	typedef struct packed {
		logic addr_latch_strobe_n;
		logic row_strobe_source_n;
		logic col_strobe_source_n;
		logic periph_wait_gen_n;
		logic rom_wait_gen_n;
	} dsg_strobes_s;
endpackage

// file: hdl/dsg_glue.sv
// external glue: dram strobe derivation, address mux, decoding and wait gating
`timescale 1ns/1ps
`default_nettype none
module dsg_glue
	import dsg_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [AD_W-1:0] ad_i,
	input wire dsg_strobes_s strobes_i,
	input wire logic [WR_W-1:0] byte_write_strobes_n_i,
	output logic [BANKS-1:0] dram_ras_n_o,
	output logic [BANKS-1:0] dram_cas_n_o,
	output logic [BANKS-1:0][WR_W-1:0] dram_we_n_o,
	output logic [DRAM_ADDR_W-1:0] dram_addr_o,
	output logic addr_mux_sel_o,
	output logic wait_request_o,
	output dsg_decode_s decode_o,
	output logic [REFRESH_ROW_W-1:0] refresh_row_o,
	output dsg_state_e cycle_state_o,
	output logic [CNT_W-1:0] half_periods_o,
	output logic [CNT_W-1:0] ras_low_periods_o
);
	logic [AD_W-1:0] latch_q;
	logic [AD_W-1:0] latch_d;
	logic [AD_W-1:0] addr_now;
	logic amux_q;
	logic amux_d;
	dsg_decode_s dec;
	dsg_state_e state_q;
	dsg_state_e state_d;
	logic [CNT_W-1:0] half_q;
	logic [CNT_W-1:0] half_d;
	logic [CNT_W-1:0] ras_cnt_q;
	logic [CNT_W-1:0] ras_cnt_d;
	logic [CNT_W-1:0] ras_len_q;
	logic [CNT_W-1:0] ras_len_d;
	logic ras_prev_q;
	logic ras_prev_d;
	logic [BANKS-1:0] ras_n;
	logic [BANKS-1:0] cas_n;
	logic [BANKS-1:0][WR_W-1:0] we_n;
	logic [DRAM_ADDR_W-1:0] row_addr;
	logic [DRAM_ADDR_W-1:0] col_addr;
	logic [DRAM_ADDR_W-1:0] mux_addr;
	logic rom_wait;
	logic io_wait;
	logic wait_req;

	// saturating half-period counter step
	function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
		sat_inc = (v == CNT_MAX) ? v : v + CNT_ONE;
	endfunction

	function automatic dsg_decode_s decode_addr(input logic [AD_W-1:0] a);
		dsg_decode_s r;
		r.refresh = ~a[REFRESH_FLAG_BIT];
		r.bank = a[BANK_BIT];
		r.ram = a[SPACE_BIT];
		r.io = ~a[SPACE_BIT] & ~a[BANK_BIT] & ~r.refresh;
		// refresh also looks like rom space, so it must not earn a wait
		r.rom = ~a[SPACE_BIT] & a[BANK_BIT] & ~r.refresh;
		decode_addr = r;
	endfunction

	// per-bank hit: ram space and the bank named by the bank bit
	function automatic logic bank_hit(input dsg_decode_s d, input int idx);
		bank_hit = d.ram & (d.bank == idx[0]);
	endfunction

	// address latch: follows the bus until the strobe falls, so decode settles early
	always_comb begin
		latch_d = latch_q;
		if (strobes_i.addr_latch_strobe_n) begin
			latch_d = ad_i;
		end
		addr_now = strobes_i.addr_latch_strobe_n ? ad_i : latch_q;
		dec = decode_addr(addr_now);
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			latch_q <= '0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// one clock of delay is the sync stand-in for the short row hold delay
	always_comb begin
		amux_d = strobes_i.row_strobe_source_n;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			amux_q <= 1'b1;
		end else begin
			amux_q <= amux_d;
		end
	end

	// row strobe reaches both banks every cycle, so any access refreshes
	always_comb begin
		ras_n = '1;
		cas_n = '1;
		we_n = '1;
		for (int i = 0; i < BANKS; i++) begin
			ras_n[i] = strobes_i.row_strobe_source_n;
			// the column strobe and the write enables are gated by decode
			cas_n[i] = ~(bank_hit(dec, i) & ~strobes_i.col_strobe_source_n);
			we_n[i] = byte_write_strobes_n_i | {WR_W{~bank_hit(dec, i)}};
		end
	end

	// row half from a buffer, column half from the latch
	always_comb begin
		row_addr = addr_now[ROW_LSB +: DRAM_ADDR_W];
		col_addr = latch_q[COL_LSB +: DRAM_ADDR_W];
		mux_addr = amux_q ? row_addr : col_addr;
	end

	// wait generators are high until their programmed fall; only inside a cycle
	always_comb begin
		rom_wait = dec.rom & strobes_i.rom_wait_gen_n;
		io_wait = dec.io & strobes_i.periph_wait_gen_n;
		wait_req = ~strobes_i.addr_latch_strobe_n & (rom_wait | io_wait);
	end

	assign dram_ras_n_o = ras_n;
	assign dram_cas_n_o = cas_n;
	assign dram_we_n_o = we_n;
	assign addr_mux_sel_o = amux_q;
	assign dram_addr_o = mux_addr;
	assign wait_request_o = wait_req;
	assign decode_o = dec;
	assign refresh_row_o = latch_q[REFRESH_ROW_LSB +: REFRESH_ROW_W];

	// cycle tracker keyed on the latch strobe edges
	always_comb begin
		state_d = state_q;
		half_d = sat_inc(half_q);
		case (state_q)
			DSG_IDLE: begin
				half_d = '0;
				if (!strobes_i.addr_latch_strobe_n) begin
					state_d = DSG_T2;
					half_d = CNT_ONE;
				end
			end
			DSG_T2: begin
				state_d = DSG_T3;
			end
			DSG_T3: begin
				state_d = DSG_T4;
			end
			DSG_T4, DSG_WAIT: begin
				state_d = wait_request_o ? DSG_WAIT : DSG_T5;
			end
			DSG_T5: begin
				state_d = strobes_i.addr_latch_strobe_n ? DSG_T6 : DSG_T5;
			end
			DSG_T6: begin
				state_d = DSG_IDLE;
				half_d = '0;
			end
			default: begin
				state_d = DSG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_q <= DSG_IDLE;
			half_q <= '0;
		end else begin
			state_q <= state_d;
			half_q <= half_d;
		end
	end

	// measured row strobe low time, latched at its rising edge
	always_comb begin
		ras_prev_d = strobes_i.row_strobe_source_n;
		ras_cnt_d = ras_cnt_q;
		ras_len_d = ras_len_q;
		if (!strobes_i.row_strobe_source_n) begin
			ras_cnt_d = ras_prev_q ? CNT_ONE : sat_inc(ras_cnt_q);
		end else if (!ras_prev_q) begin
			ras_len_d = ras_cnt_q;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ras_prev_q <= 1'b1;
			ras_cnt_q <= '0;
			ras_len_q <= '0;
		end else begin
			ras_prev_q <= ras_prev_d;
			ras_cnt_q <= ras_cnt_d;
			ras_len_q <= ras_len_d;
		end
	end

	assign cycle_state_o = state_q;
	assign half_periods_o = half_q;
	assign ras_low_periods_o = ras_len_q;
endmodule
`default_nettype wire

// file: verif/dsg_monitor.sv
// concurrent checks on the glue ports
`timescale 1ns/1ps
`default_nettype none
module dsg_monitor
	import dsg_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire dsg_strobes_s strobes_i,
	input wire logic [BANKS-1:0] dram_ras_n_o,
	input wire logic [BANKS-1:0] dram_cas_n_o,
	input wire logic [BANKS-1:0][WR_W-1:0] dram_we_n_o,
	input wire logic addr_mux_sel_o,
	input wire logic wait_request_o,
	input wire dsg_decode_s decode_o,
	input wire logic [CNT_W-1:0] ras_low_periods_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	ras_both_a: assert property (dram_ras_n_o == {2{strobes_i.row_strobe_source_n}})
		else $error("row strobe differs");
	cas_refresh_a: assert property (decode_o.refresh |-> dram_cas_n_o == 2'b11)
		else $error("cas in refresh");
	cas_bank_a: assert property (decode_o.ram && !strobes_i.col_strobe_source_n
		|-> dram_cas_n_o == (decode_o.bank ? 2'b01 : 2'b10)) else $error("wrong cas");
	mux_delay_a: assert property ($fell(strobes_i.row_strobe_source_n)
		|=> !addr_mux_sel_o [*3] ##1 addr_mux_sel_o) else $error("mux select");
	we_gate_a: assert property (!decode_o.ram |-> &dram_we_n_o)
		else $error("write leaked");
	wait_ram_a: assert property (decode_o.ram || decode_o.refresh |-> !wait_request_o)
		else $error("wait in ram");
	wait_rom_a: assert property (decode_o.rom && !strobes_i.addr_latch_strobe_n
		&& strobes_i.rom_wait_gen_n |-> wait_request_o) else $error("rom wait");
	ras_len_a: assert property ($rose(strobes_i.row_strobe_source_n)
		|-> ##[0:2] ras_low_periods_o == 8'h03) else $error("ras length");
endmodule
`default_nettype wire

// file: verif/dsg_proc_model.sv
// processor memory interface: one fastest cycle per start, waits in T4
`timescale 1ns/1ps
`default_nettype none
module dsg_proc_model
	import dsg_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire logic wr_i,
	input wire logic [AD_W-1:0] addr_i,
	input wire logic wait_i,
	output logic [AD_W-1:0] ad_o,
	output dsg_strobes_s strobes_o,
	output logic [WR_W-1:0] wr_n_o,
	output logic [2:0] ph_o
);
	logic [1:0] w_q;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ph_o <= 3'h0;
			w_q <= 2'h0;
		end else if (ph_o == 3'h0) begin
			ph_o <= start_i ? 3'h1 : 3'h0;
			w_q <= 2'h0;
		end else if (ph_o == 3'h4 && wait_i) begin
			w_q <= w_q + 2'h1;
		end else begin
			ph_o <= (ph_o == 3'h6) ? 3'h0 : ph_o + 3'h1;
		end
	end
	// bus shows inverted address outside T1/T2 so a stale latch is seen
	assign ad_o = (ph_o == 3'h1 || ph_o == 3'h2) ? addr_i : ~addr_i;
	assign strobes_o.addr_latch_strobe_n = !(ph_o >= 3'h2 && ph_o <= 3'h5);
	// row strobe length is fixed, so waits in T4 do not stretch it
	assign strobes_o.row_strobe_source_n = !(ph_o == 3'h2 || ph_o == 3'h3 || (ph_o == 3'h4 && w_q == 2'h0));
	assign strobes_o.col_strobe_source_n = !(ph_o >= 3'h3 && ph_o <= 3'h5);
	assign strobes_o.periph_wait_gen_n = !(ph_o >= 3'h4 && w_q >= 2'h1);
	assign strobes_o.rom_wait_gen_n = !(ph_o >= 3'h4 && w_q >= 2'h2);
	assign wr_n_o = {WR_W{strobes_o.col_strobe_source_n || !wr_i}};
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// bench: processor model runs ram, rom, io and refresh cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dsg_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic start = 1'b0;
	logic wr = 1'b0;
	logic [AD_W-1:0] addr = '0;
	logic [AD_W-1:0] ad;
	dsg_strobes_s stb;
	logic [WR_W-1:0] wrn;
	logic [2:0] ph;
	logic [BANKS-1:0] ras_n, cas_n, cs, ws;
	logic [BANKS-1:0][WR_W-1:0] we_n;
	logic [DRAM_ADDR_W-1:0] da, row, col;
	logic sel, wt;
	dsg_decode_s dec;
	logic [REFRESH_ROW_W-1:0] rrow, rr;
	logic [CNT_W-1:0] rlen, hp;
	dsg_state_e st;
	logic [31:0] len, rl;
	int n_fail = 0;
	int samples_checked = 0;
	dsg_glue DUT(.clk_i(clk_i), .reset_i(reset_i), .ad_i(ad), .strobes_i(stb), .byte_write_strobes_n_i(wrn),
		.dram_ras_n_o(ras_n), .dram_cas_n_o(cas_n), .dram_we_n_o(we_n), .dram_addr_o(da), .addr_mux_sel_o(sel),
		.wait_request_o(wt), .decode_o(dec), .refresh_row_o(rrow), .cycle_state_o(st), .half_periods_o(hp),
		.ras_low_periods_o(rlen));
	dsg_proc_model u_proc(.clk_i(clk_i), .reset_i(reset_i), .start_i(start), .wr_i(wr), .addr_i(addr),
		.wait_i(wt), .ad_o(ad), .strobes_o(stb), .wr_n_o(wrn), .ph_o(ph));
	initial forever #12.5 clk_i = ~clk_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks=%0d fails=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// one processor cycle, observed at falling edges
	task automatic run(input logic [AD_W-1:0] a, input logic w, input logic [31:0] n, input logic [1:0] c);
		@(posedge clk_i);
		addr <= a;
		wr <= w;
		start <= 1'b1;
		@(posedge clk_i);
		start <= 1'b0;
		len = 0;
		rl = 0;
		cs = 2'b00;
		ws = 2'b00;
		@(negedge clk_i);
		while (ph != 3'h0 && len < 40) begin
			len++;
			cs |= ~cas_n;
			ws |= ~{&we_n[1], &we_n[0]};
			rl += 32'(ras_n == 2'b00);
			if (ph == 3'h2) row = da;
			if (ph == 3'h3) col = da;
			if (ph == 3'h3) rr = rrow;
			@(negedge clk_i);
		end
		if (len >= 40) begin
			n_fail++;
			print_verdict();
		end
		chk(len, n);
		chk(32'(st), 32'(DSG_T6));
		chk(32'(hp), n - 32'h1);
		chk(32'(cs), 32'(c));
		chk(32'(ws), 32'(w ? c : 2'b00));
		chk(rl, 3);
	endtask
	task automatic t_ram;
		for (int b = 0; b < 2; b++) begin
			run(b ? 32'h8013_6F5E : 32'h8003_6F5E, 1'b1, 6, b ? 2'b10 : 2'b01);
			chk(32'(row), 32'(addr[10:2]));
			chk(32'(col), 32'(addr[19:11]));
			chk(32'(rlen), 3);
		end
		$display("ram done");
	endtask
	task automatic t_slow;
		run(32'h0010_0002, 1'b1, 8, 2'b00);
		run(32'h0000_0002, 1'b1, 7, 2'b00);
		$display("rom io done");
	endtask
	task automatic t_refresh;
		run(32'h7FFF_FAD5, 1'b0, 6, 2'b00);
		chk(32'(rr), 32'h2B5);
		$display("refresh done");
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		t_ram();
		t_slow();
		t_refresh();
		print_verdict();
	end
endmodule
bind dsg_glue dsg_monitor u_mon(.clk_i(clk_i), .reset_i(reset_i), .strobes_i(strobes_i),
	.dram_ras_n_o(dram_ras_n_o), .dram_cas_n_o(dram_cas_n_o), .dram_we_n_o(dram_we_n_o),
	.addr_mux_sel_o(addr_mux_sel_o), .wait_request_o(wait_request_o), .decode_o(decode_o),
	.ras_low_periods_o(ras_low_periods_o));
`default_nettype wire
